// file: design/tos_pkg.sv
// Package holding the offsets, field positions and state layout of the fault-status bank
package tos_pkg;

  // Register offsets on the host register port
  localparam logic [7:0] TOS_OFS_CRIT = 8'hb4;
  localparam logic [7:0] TOS_OFS_HOT = 8'hb5;
  localparam logic [7:0] TOS_OFS_OC = 8'hb6;

  // Register and field widths
  localparam int TOS_REG_W = 8;
  localparam int TOS_TEMP_W = 5;
  localparam int TOS_OC_W = 3;
  localparam int TOS_DET_W = TOS_TEMP_W + TOS_TEMP_W + TOS_OC_W;

  // Temperature flag positions, shared by the critical and the warm register
  localparam int TOS_BIT_REST_OF_DIE = 4;
  localparam int TOS_BIT_DDR_TERM_LDO = 3;
  localparam int TOS_BIT_UPPER_RIGHT = 2;
  localparam int TOS_BIT_UPPER_LEFT = 1;
  localparam int TOS_BIT_LOWER_RIGHT = 0;

  // Overcurrent flag positions
  localparam int TOS_BIT_CONTROLLER_SIX = 2;
  localparam int TOS_BIT_CONTROLLER_TWO = 1;
  localparam int TOS_BIT_CONTROLLER_ONE = 0;

  // Reset values
  localparam logic [TOS_TEMP_W-1:0] TOS_RST_TEMP = 5'h00;
  localparam logic [TOS_OC_W-1:0] TOS_RST_OC = 3'h0;
  localparam logic [TOS_REG_W-1:0] TOS_RST_RDATA = 8'h00;
  localparam logic [TOS_DET_W-1:0] TOS_RST_SYNC = 13'h0000;

  // Reserved upper bits of each register
  localparam logic [TOS_REG_W-TOS_TEMP_W-1:0] TOS_RSV_TEMP = 3'h0;
  localparam logic [TOS_REG_W-TOS_OC_W-1:0] TOS_RSV_OC = 5'h00;

  // State of the flag bank
  typedef struct packed {
    logic [TOS_TEMP_W-1:0] crit;
    logic [TOS_TEMP_W-1:0] hot;
    logic [TOS_OC_W-1:0] oc;
    logic [TOS_REG_W-1:0] rdata;
    logic rvalid;
  } tos_state_t;

  // State of the detector synchroniser
  typedef struct packed {
    logic [TOS_DET_W-1:0] s1;
    logic [TOS_DET_W-1:0] s2;
  } tos_sync_t;

endpackage : tos_pkg

// file: design/tos_sync.sv
// Two-stage synchroniser for the asynchronous detector levels
`timescale 1ns/10ps
module tos_sync
  import tos_pkg::*;
(
  input wire logic I_CLK, // System clock
  input wire logic I_RST, // Synchronous reset, active high
  input wire logic [TOS_DET_W-1:0] i_async, // Detector levels from the analog side
  output logic [TOS_DET_W-1:0] o_sync // Levels safe to use in this domain
);

  tos_sync_t st_q;
  tos_sync_t st_d;

  // First stage feeds only the second; nothing else looks at it
  always_comb begin
    st_d = st_q;
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
  end

  // State register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_q <= '{s1: TOS_RST_SYNC, s2: TOS_RST_SYNC};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.s2;

endmodule : tos_sync

// file: design/tos_fault_status.sv
// Sticky thermal and overcurrent fault-status register bank
//
// Summary of operation
// - Critical flags at 0xb4 set above threshold
// - Five sensors feed critical and warm flags
// - Critical bits: die, term LDO, corners
// - Warm flags at 0xb5 set above threshold
// - Warm bits mirror critical bit placement
// - Overcurrent flags at 0xb6 per controller
// - Overcurrent bits six, two, one; rest reserved
// - Flags stay set until written one
// - All registers reset to zero
`timescale 1ns/10ps
module tos_fault_status
  import tos_pkg::*;
(
  input wire logic I_CLK, // System clock, 100 MHz
  input wire logic I_RST, // Synchronous reset, active high
  input wire logic [TOS_TEMP_W-1:0] I_CRIT, // Critical-threshold detector levels
  input wire logic [TOS_TEMP_W-1:0] I_HOT, // Warm-threshold detector levels
  input wire logic [TOS_OC_W-1:0] I_OC, // Low-side switch overcurrent levels
  input wire logic [7:0] I_ADDR, // Register offset
  input wire logic I_WR, // Write strobe, one cycle
  input wire logic [TOS_REG_W-1:0] I_WDATA, // Write data, ones clear flags
  input wire logic I_RD, // Read strobe, one cycle
  output logic [TOS_REG_W-1:0] O_RDATA, // Read data, registered
  output logic O_RVALID // Read data valid, one cycle
);

  tos_state_t st_q;
  tos_state_t st_d;
  logic [TOS_DET_W-1:0] det_async;
  logic [TOS_DET_W-1:0] det_sync;
  logic [TOS_TEMP_W-1:0] crit_evt;
  logic [TOS_TEMP_W-1:0] hot_evt;
  logic [TOS_OC_W-1:0] oc_evt;
  logic hit_crit;
  logic hit_hot;
  logic hit_oc;
  logic [TOS_TEMP_W-1:0] crit_clr;
  logic [TOS_TEMP_W-1:0] hot_clr;
  logic [TOS_OC_W-1:0] oc_clr;

  // five sensor lines per threshold
  // Detector lines are analog-derived and asynchronous, so bundle them for one crossing
  assign det_async = {I_CRIT, I_HOT, I_OC};

  // Pulses shorter than a clock period may be missed; the analog side must stretch them
  tos_sync u_sync (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .i_async(det_async),
    .o_sync(det_sync)
  );

  // Split the synchronised levels back into their groups
  // Bundle order is critical, warm, overcurrent from the top bit down
  assign crit_evt = det_sync[TOS_DET_W-1 -: TOS_TEMP_W];
  assign hot_evt = det_sync[TOS_OC_W +: TOS_TEMP_W];
  assign oc_evt = det_sync[TOS_OC_W-1:0];

  // Address decode for the three mapped offsets
  // Full eight-bit compare, so no other offset aliases onto a flag register
  assign hit_crit = (I_ADDR == TOS_OFS_CRIT);
  assign hit_hot = (I_ADDR == TOS_OFS_HOT);
  assign hit_oc = (I_ADDR == TOS_OFS_OC);

  // A write to any other offset leaves all three masks at zero
  // write-one clear masks
  // reserved write bits are dropped here
  assign crit_clr = (I_WR && hit_crit) ? I_WDATA[TOS_TEMP_W-1:0] : TOS_RST_TEMP;
  assign hot_clr = (I_WR && hit_hot) ? I_WDATA[TOS_TEMP_W-1:0] : TOS_RST_TEMP;
  assign oc_clr = (I_WR && hit_oc) ? I_WDATA[TOS_OC_W-1:0] : TOS_RST_OC;

  // Next state of the flag bank and the read port
  always_comb begin
    st_d = st_q;
    // bit order follows the sensor bus
    // set wins over a clear in the same cycle
    st_d.crit = (st_q.crit & ~crit_clr) | crit_evt;
    st_d.hot = (st_q.hot & ~hot_clr) | hot_evt;
    st_d.oc = (st_q.oc & ~oc_clr) | oc_evt;
    // Reads see the flags before this cycle's update, which keeps data one edge late
    st_d.rvalid = I_RD;
    // Idle and unmapped cycles return zero, so stale data never looks valid
    st_d.rdata = TOS_RST_RDATA;
    if (I_RD) begin
      unique case (1'b1)
        hit_crit: st_d.rdata = {TOS_RSV_TEMP, st_q.crit};
        hit_hot: st_d.rdata = {TOS_RSV_TEMP, st_q.hot};
        hit_oc: st_d.rdata = {TOS_RSV_OC, st_q.oc};
        default: st_d.rdata = TOS_RST_RDATA;
      endcase
    end
  end

  // State register
  // Synchronous reset only; the whole bank clears in one edge
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_q <= '{crit: TOS_RST_TEMP, hot: TOS_RST_TEMP, oc: TOS_RST_OC,
                rdata: TOS_RST_RDATA, rvalid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register
  // No logic sits between these flops and the pins, so reads carry no glitches
  assign O_RDATA = st_q.rdata;
  assign O_RVALID = st_q.rvalid;

  // Checks on the flag bank and the read port
  // A reset in any of the last three edges empties the pipeline, so skip those
  // critical input reaches its flag
  a_crit_latch: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST, 1) && !$past(I_RST, 2) && !$past(I_RST, 3) |->
      ((st_q.crit | ~$past(I_CRIT, 3)) == {TOS_TEMP_W{1'b1}}))
    else $error("critical flag missed a detector level");

  a_hot_latch: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST, 1) && !$past(I_RST, 2) && !$past(I_RST, 3) |->
      ((st_q.hot | ~$past(I_HOT, 3)) == {TOS_TEMP_W{1'b1}}))
    else $error("warm flag missed a detector level");

  a_oc_latch: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST, 1) && !$past(I_RST, 2) && !$past(I_RST, 3) |->
      ((st_q.oc | ~$past(I_OC, 3)) == {TOS_OC_W{1'b1}}))
    else $error("overcurrent flag missed a detector level");

  // critical flag falls only on a write of one
  a_crit_clear: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST) && (($past(st_q.crit) & ~st_q.crit) != TOS_RST_TEMP) |->
      ($past(I_WR) && $past(I_ADDR) == TOS_OFS_CRIT &&
       (($past(st_q.crit) & ~st_q.crit & ~$past(I_WDATA[TOS_TEMP_W-1:0])) == TOS_RST_TEMP)))
    else $error("critical flag cleared without a write of one");

  // overcurrent flag survives a write of zero
  a_oc_keep: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_WR && hit_oc && I_WDATA == 8'h00) |=> (st_q.oc & $past(st_q.oc)) == $past(st_q.oc))
    else $error("overcurrent flag lost on a write of zero");

  // critical read returns the flags in place
  a_crit_read: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_RD && hit_crit) |=> (O_RVALID && O_RDATA == {TOS_RSV_TEMP, $past(st_q.crit)}))
    else $error("critical read data wrong");

  // warm read returns the flags in place
  a_hot_read: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_RD && hit_hot) |=> (O_RVALID && O_RDATA == {TOS_RSV_TEMP, $past(st_q.hot)}))
    else $error("warm read data wrong");

  // overcurrent read keeps reserved bits at zero
  a_oc_read: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_RD && hit_oc) |=> (O_RVALID && O_RDATA[7:TOS_OC_W] == TOS_RSV_OC &&
      O_RDATA[TOS_OC_W-1:0] == $past(st_q.oc)))
    else $error("overcurrent read data wrong");

  // a warm flag only rises from its own sensor
  a_hot_cause: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    ((st_q.hot & ~$past(st_q.hot) & ~$past(hot_evt)) == TOS_RST_TEMP))
    else $error("warm flag rose without its sensor");

  // Checked at the release edge, where the last reset edge has just cleared the bank
  // reset leaves the bank clear and quiet
  a_reset_clear: assert property (
    @(posedge I_CLK)
    $fell(I_RST) |-> (st_q.crit == TOS_RST_TEMP && st_q.hot == TOS_RST_TEMP &&
      st_q.oc == TOS_RST_OC && !O_RVALID && O_RDATA == TOS_RST_RDATA))
    else $error("bank not clear after reset");

  // No read strobe means no read answer
  a_read_quiet: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !I_RD |=> (!O_RVALID && O_RDATA == TOS_RST_RDATA))
    else $error("read answer without a strobe");

  // warm flag falls only on a write of one
  a_hot_clear: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST) && (($past(st_q.hot) & ~st_q.hot) != TOS_RST_TEMP) |->
      ($past(I_WR) && $past(I_ADDR) == TOS_OFS_HOT &&
       (($past(st_q.hot) & ~st_q.hot & ~$past(I_WDATA[TOS_TEMP_W-1:0])) == TOS_RST_TEMP)))
    else $error("warm flag cleared without a write of one");

  // overcurrent flag falls only on a write of one
  a_oc_clear: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST) && (($past(st_q.oc) & ~st_q.oc) != TOS_RST_OC) |->
      ($past(I_WR) && $past(I_ADDR) == TOS_OFS_OC &&
       (($past(st_q.oc) & ~st_q.oc & ~$past(I_WDATA[TOS_OC_W-1:0])) == TOS_RST_OC)))
    else $error("overcurrent flag cleared without a write of one");

  // a write of one clears a flag whose detector is quiet
  // A detector still high makes the clear lose on purpose, so those bits are left out
  for (genvar k = 0; k < TOS_TEMP_W; k++) begin : g_temp_clr
    a_crit_bit_clr: assert property (
      @(posedge I_CLK) disable iff (I_RST)
      (I_WR && hit_crit && I_WDATA[k] && !crit_evt[k]) |=> !st_q.crit[k])
      else $error("critical flag kept after a write of one");
    a_hot_bit_clr: assert property (
      @(posedge I_CLK) disable iff (I_RST)
      (I_WR && hit_hot && I_WDATA[k] && !hot_evt[k]) |=> !st_q.hot[k])
      else $error("warm flag kept after a write of one");
  end : g_temp_clr

  // same per-bit clear for the three overcurrent flags
  // Reserved bits above them are never stored, so only the low bits are checked
  for (genvar k = 0; k < TOS_OC_W; k++) begin : g_oc_clr
    a_oc_bit_clr: assert property (
      @(posedge I_CLK) disable iff (I_RST)
      (I_WR && hit_oc && I_WDATA[k] && !oc_evt[k]) |=> !st_q.oc[k])
      else $error("overcurrent flag kept after a write of one");
  end : g_oc_clr

  // critical flags survive a write of zero
  a_crit_keep: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_WR && hit_crit && I_WDATA[TOS_TEMP_W-1:0] == TOS_RST_TEMP) |=>
      ((st_q.crit | ~$past(st_q.crit)) == {TOS_TEMP_W{1'b1}}))
    else $error("critical flag lost on a write of zero");

  // warm flags survive a write of zero
  a_hot_keep: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_WR && hit_hot && I_WDATA[TOS_TEMP_W-1:0] == TOS_RST_TEMP) |=>
      ((st_q.hot | ~$past(st_q.hot)) == {TOS_TEMP_W{1'b1}}))
    else $error("warm flag lost on a write of zero");

  // Flags are sticky, so without a write to their offset none may fall
  // critical flags hold with no write
  a_crit_hold: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !(I_WR && hit_crit) |=> ((st_q.crit | ~$past(st_q.crit)) == {TOS_TEMP_W{1'b1}}))
    else $error("critical flag dropped with no write");

  // warm flags hold with no write
  a_hot_hold: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !(I_WR && hit_hot) |=> ((st_q.hot | ~$past(st_q.hot)) == {TOS_TEMP_W{1'b1}}))
    else $error("warm flag dropped with no write");

  // overcurrent flags hold with no write
  a_oc_hold: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !(I_WR && hit_oc) |=> ((st_q.oc | ~$past(st_q.oc)) == {TOS_OC_W{1'b1}}))
    else $error("overcurrent flag dropped with no write");

  // a critical flag only rises from its own sensor
  a_crit_cause: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    ((st_q.crit & ~$past(st_q.crit) & ~$past(crit_evt)) == TOS_RST_TEMP))
    else $error("critical flag rose without its sensor");

  // an overcurrent flag only rises from its own controller
  a_oc_cause: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    ((st_q.oc & ~$past(st_q.oc) & ~$past(oc_evt)) == TOS_RST_OC))
    else $error("overcurrent flag rose without its controller");

  // A lost clear is safer than a lost fault, so an active detector always wins
  // critical detector beats a clear
  a_crit_set_wins: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST) |-> ((st_q.crit | ~$past(crit_evt)) == {TOS_TEMP_W{1'b1}}))
    else $error("critical clear beat an active detector");

  a_hot_set_wins: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST) |-> ((st_q.hot | ~$past(hot_evt)) == {TOS_TEMP_W{1'b1}}))
    else $error("warm clear beat an active detector");

  a_oc_set_wins: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !$past(I_RST) |-> ((st_q.oc | ~$past(oc_evt)) == {TOS_OC_W{1'b1}}))
    else $error("overcurrent clear beat an active detector");

  // Reads are never refused; the host may poll any offset
  // an unmapped read answers with zero
  a_unmapped_read: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_RD && !hit_crit && !hit_hot && !hit_oc) |=> (O_RVALID && O_RDATA == TOS_RST_RDATA))
    else $error("unmapped read returned data");

endmodule : tos_fault_status

// file: verification/tos_host_model.sv
// Host model driving the strobe and address register port
`timescale 1ns/10ps
module tos_host_model (
  input wire logic i_clk, // System clock
  input wire logic [7:0] i_rdata, // Read data from the bank
  input wire logic i_rvalid, // Read data valid
  output logic [7:0] o_addr, // Register offset
  output logic o_wr, // Write strobe
  output logic [7:0] o_wdata, // Write data
  output logic o_rd // Read strobe
);
  // Idle port at time zero
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] w);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = w;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Released lines flip so stale values never look valid
    o_addr = ~a;
    o_wdata = ~w;
  endtask : wr_reg

  // Read answer lands one edge after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    d = i_rdata;
    v = i_rvalid;
    o_rd = 1'b0;
    o_addr = ~a;
  endtask : rd_reg
endmodule : tos_host_model

// file: verification/tos_fault_status_tb_top.sv
// Self-checking bench for the fault-status bank
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tos_fault_status_tb_top;
  import tos_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic [TOS_TEMP_W-1:0] crit = '0;
  logic [TOS_TEMP_W-1:0] hot = '0;
  logic [TOS_OC_W-1:0] oc = '0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid, v;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] m[3];

  tos_fault_status uut (.I_CLK(I_CLK), .I_RST(I_RST), .I_CRIT(crit), .I_HOT(hot),
    .I_OC(oc), .I_ADDR(addr), .I_WR(wr), .I_WDATA(wdata), .I_RD(rd),
    .O_RDATA(rdata), .O_RVALID(rvalid));
  tos_host_model host (.i_clk(I_CLK), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));

  // Free-running 100 MHz clock
  initial begin
    forever #5 I_CLK = ~I_CLK;
  end

  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // Hang guard, well above the roughly seven hundred cycles the tests need
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc > 6000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input int r);
    host.rd_reg(8'(TOS_OFS_CRIT + r), d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("flags", m[r], d)
  endtask : chk

  // Pulse detector levels, wait out the synchroniser, then update the model
  task automatic det(input logic [4:0] c, input logic [4:0] h, input logic [2:0] o);
    @(negedge I_CLK);
    crit = c;
    hot = h;
    oc = o;
    repeat (2) @(negedge I_CLK);
    crit = '0;
    hot = '0;
    oc = '0;
    repeat (3) @(negedge I_CLK);
    m[0] |= {3'h0, c};
    m[1] |= {3'h0, h};
    m[2] |= {5'h00, o};
  endtask : det

  task automatic clr(input int r, input logic [7:0] w);
    host.wr_reg(8'(TOS_OFS_CRIT + r), w);
    m[r] &= ~w;
  endtask : clr

  initial begin
    void'($urandom(19109));
    m = '{default: 8'h00};
    repeat (10) @(negedge I_CLK);
    I_RST = 1'b0;
    // zero after reset, unmapped reads zero
    for (int r = 0; r < 3; r++) chk(r);
    host.rd_reg(8'hb7, d, v);
    `CHK("unmapped", 8'h00, d)
    `CHK("unmapped valid", 1'b1, v)
    $display("Test reset done");
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < (r < 2 ? 5 : 3); k++) begin
        det(r == 0 ? 5'(1 << k) : 5'h00, r == 1 ? 5'(1 << k) : 5'h00, r == 2 ? 3'(1 << k) : 3'h0);
        for (int q = 0; q < 3; q++) chk(q);
        clr(r, 8'h00);
        chk(r);
        clr(r, 8'(1 << k));
        chk(r);
      end
    end
    $display("Test placement done");
    // random faults and clears, reserved bits included
    for (int i = 0; i < 40; i++) begin
      det(5'($urandom), 5'($urandom), 3'($urandom));
      clr(i % 3, 8'($urandom));
      chk(i % 3);
    end
    $display("Test random done");
    @(negedge I_CLK);
    crit = 5'h01;
    repeat (3) @(negedge I_CLK);
    host.wr_reg(TOS_OFS_CRIT, 8'hff);
    m[0] = 8'h01;
    chk(0);
    crit = '0;
    repeat (3) @(negedge I_CLK);
    clr(0, 8'h01);
    chk(0);
    $display("Test set wins done");
    // reset in mid-run wipes all flags
    det(5'h1f, 5'h1f, 3'h7);
    for (int r = 0; r < 3; r++) chk(r);
    I_RST = 1'b1;
    repeat (3) @(negedge I_CLK);
    I_RST = 1'b0;
    m = '{default: 8'h00};
    for (int r = 0; r < 3; r++) chk(r);
    $display("Test mid reset done");
    final_report();
  end
endmodule : tos_fault_status_tb_top
